// *** rtl/wake_offload_pkg.sv ***
// Constants, field layout and carrier types for the wake and offload
// control/status register bank.
// Assumes a 12-bit AXI4-Lite byte address space and a single 100 MHz clock.
package wake_offload_pkg;

   // Bus geometry
   localparam int          ADDR_W = 12;
   localparam int          DATA_W = 32;
   localparam int          STRB_W = 4;

   // Register byte addresses
   localparam logic [11:0] CTL_OFFSET        = 12'h600;
   localparam logic [11:0] IRQ_STAT_OFFSET   = 12'h604;
   localparam logic [11:0] IRQ_MASK_OFFSET   = 12'h608;
   localparam logic [11:0] RESUME_OPT_OFFSET = 12'h60C;

   // Control/status word field positions
   localparam int          CHECKSUM_BYPASS_BIT  = 31;
   localparam int          FWD_ARP_BIT          = 10;
   localparam int          FWD_SOLICIT_BIT      = 9;
   localparam int          ADVERT_SRC_SEL_BIT   = 8;
   localparam int          SOLICIT_SEEN_BIT     = 7;
   localparam int          ARP_SEEN_BIT         = 6;
   localparam int          V6_SYN_SEEN_BIT      = 5;
   localparam int          V4_SYN_SEEN_BIT      = 4;
   localparam int          SOLICIT_OFFLOAD_BIT  = 3;
   localparam int          ARP_OFFLOAD_BIT      = 2;
   localparam int          V6_SYN_WAKE_BIT      = 1;
   localparam int          V4_SYN_WAKE_BIT      = 0;

   // Plain read/write bits and write-one-to-clear bits of the control word
   localparam logic [31:0] CTL_RW_MASK  = 32'h8000_070F;
   localparam logic [31:0] CTL_W1C_MASK = 32'h0000_00F0;
   localparam logic [31:0] CTL_RESET    = 32'h0000_0000;

   // Resume option word
   localparam int          RESUME_OPT_W       = 2;
   localparam int          RES_CLR_STATUS_BIT = 0;
   localparam int          RES_CLR_ENABLE_BIT = 1;

   // Interrupt status and mask layout
   localparam int          IRQ_W           = 5;
   localparam int          IRQ_ARP_BIT     = 0;
   localparam int          IRQ_SOLICIT_BIT = 1;
   localparam int          IRQ_V4_SYN_BIT  = 2;
   localparam int          IRQ_V6_SYN_BIT  = 3;
   localparam int          IRQ_WAKE_BIT    = 4;

   // AXI responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_DECERR = 2'h3;

   // Frame class reported by the receive parser
   typedef enum logic [2:0] {
      FRAME_OTHER   = 3'b000,
      FRAME_ARP     = 3'b001,
      FRAME_SOLICIT = 3'b010,
      FRAME_V4_SYN  = 3'b011,
      FRAME_V6_SYN  = 3'b100
   } frame_kind_e;

   // Result of checks at the end of one received frame
   typedef struct packed {
      logic        done;       // One-cycle end-of-frame strobe
      frame_kind_e kind;       // Frame class
      logic        targets_me; // Addressed to this device
      logic        fcs_ok;     // FCS agrees
      logic        ip_csum_ok; // IP header checksum agrees (1 if none)
      logic        l4_csum_ok; // TCP or ICMP checksum agrees (1 if none)
   } rx_check_s;

   // Decision handed back to the offload and receive datapath
   typedef struct packed {
      logic valid;       // One-cycle, one per rx_check.done
      logic pass;        // Forward the frame to the receive datapath
      logic answer_arp;  // Build an ARP reply
      logic answer_ns;   // Build a neighbor advertisement
      logic wake;        // Raise a wakeup
   } rx_verdict_s;

   // Whole state of the register bank
   typedef struct packed {
      logic                    aw_held;
      logic [ADDR_W-1:0]       awaddr;
      logic                    w_held;
      logic [DATA_W-1:0]       wdata;
      logic [STRB_W-1:0]       wstrb;
      logic                    awready;
      logic                    wready;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    arready;
      logic                    rvalid;
      logic [DATA_W-1:0]       rdata;
      logic [1:0]              rresp;
      logic [DATA_W-1:0]       ctl;
      logic [IRQ_W-1:0]        irq_stat;
      logic [IRQ_W-1:0]        irq_mask;
      logic [RESUME_OPT_W-1:0] resume_opt;
      rx_verdict_s             verdict;
      logic                    irq;
      logic                    advert_sel;
   } state_s;

endpackage

// *** rtl/wake_offload_ctrl_status.sv ***
// Wake and offload control/status register bank with its receive verdict.
// Assumes an AXI4-Lite master on clk, a receive parser that reports one
// end-of-frame check record per frame on the same clock, and a resume
// sequencer that pulses resume_done on the same clock.
//
// Notes on behaviour
// - With bypass clear, a frame counts only if FCS, IP header and TCP or ICMP checksums all agree.
// - With bypass set, only the FCS must agree and IP, ICMP and TCP checksum errors are ignored.
// - An offloaded ARP frame for this device is forwarded when the forward-ARP bit is 1, else sunk.
// - An offloaded NS frame for this device is forwarded when the forward-NS bit is 1, else sunk.
// - The advertisement source is the solicit destination register when select is set, else the NS target.
// - A valid NS frame sets the NS-seen flag.
// - A valid ARP frame sets the ARP-seen flag, which holds until software writes a one to it.
// - A valid IPv6 SYN frame sets the IPv6 SYN-seen flag, cleared by a software write of one.
// - A valid IPv4 SYN frame sets the IPv4 SYN-seen flag, cleared by a software write of one.
// - A finished resume clears both SYN-seen flags when resume-clears-status is set.
// - NS frames are answered only while NS offload is on.
// - ARP frames are answered only while ARP offload is on.
// - An IPv6 SYN frame wakes only while the IPv6 SYN wake enable is set.
// - An IPv4 SYN frame wakes only while the IPv4 SYN wake enable is set.
// - A finished resume clears both SYN wake enables when resume-clears-enables is set.
`timescale 1ns/1ps

module wake_offload_ctrl_status (
   input  wire logic                                clk,         // 100 MHz clock
   input  wire logic                                reset,       // Synchronous, active high
   input  wire logic [wake_offload_pkg::ADDR_W-1:0] awaddr,      // Write address
   input  wire logic                                awvalid,     // Write address valid
   output logic                                     awready,     // Write address ready
   input  wire logic [wake_offload_pkg::DATA_W-1:0] wdata,       // Write data
   input  wire logic [wake_offload_pkg::STRB_W-1:0] wstrb,       // Write byte lanes
   input  wire logic                                wvalid,      // Write data valid
   output logic                                     wready,      // Write data ready
   output logic [1:0]                               bresp,       // Write response
   output logic                                     bvalid,      // Write response valid
   input  wire logic                                bready,      // Write response ready
   input  wire logic [wake_offload_pkg::ADDR_W-1:0] araddr,      // Read address
   input  wire logic                                arvalid,     // Read address valid
   output logic                                     arready,     // Read address ready
   output logic [wake_offload_pkg::DATA_W-1:0]      rdata,       // Read data
   output logic [1:0]                               rresp,       // Read response
   output logic                                     rvalid,      // Read data valid
   input  wire logic                                rready,      // Read data ready
   input  wire wake_offload_pkg::rx_check_s         rx_check,    // End-of-frame checks
   input  wire logic                                resume_done, // Resume sequence finished
   output wake_offload_pkg::rx_verdict_s            rx_verdict,  // Frame decision, registered
   output logic                                     advert_sel,  // NA source from dest register
   output logic                                     irq          // Level interrupt
);
   import wake_offload_pkg::*;

   state_s            state_reg;
   state_s            state_next;
   logic              do_write;
   logic              checks_ok;
   logic [DATA_W-1:0] wmask;
   logic [DATA_W-1:0] ctl_set;
   logic [IRQ_W-1:0]  irq_set;
   logic [DATA_W-1:0] rd_word;

   // Expand byte-lane strobes into a bit mask
   function automatic logic [DATA_W-1:0] lane_mask(input logic [STRB_W-1:0] strb);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int i = 0; i < STRB_W; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

   // Read data for one address; unmapped locations read zero
   function automatic logic [DATA_W-1:0] read_word(input state_s s,
                                                  input logic [ADDR_W-1:0] a);
      logic [DATA_W-1:0] d;
      d = '0;
      case (a)
         CTL_OFFSET:        d = s.ctl;
         IRQ_STAT_OFFSET:   d[IRQ_W-1:0] = s.irq_stat;
         IRQ_MASK_OFFSET:   d[IRQ_W-1:0] = s.irq_mask;
         RESUME_OPT_OFFSET: d[RESUME_OPT_W-1:0] = s.resume_opt;
         default:           d = '0;
      endcase
      return d;
   endfunction

   // Mapped address check, used by both channels
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return (a == CTL_OFFSET) || (a == IRQ_STAT_OFFSET) ||
             (a == IRQ_MASK_OFFSET) || (a == RESUME_OPT_OFFSET);
   endfunction

   // Next-state logic: bus slave, register writes, frame events
   always_comb begin
      state_next = state_reg;
      state_next.verdict = '0;
      ctl_set = '0;
      irq_set = '0;
      wmask = lane_mask(state_reg.wstrb);
      do_write = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;

      // Address and data are latched independently, so either may come first
      if (awvalid && state_reg.awready) begin
         state_next.aw_held = 1'b1;
         state_next.awaddr = awaddr;
      end
      if (wvalid && state_reg.wready) begin
         state_next.w_held = 1'b1;
         state_next.wdata = wdata;
         state_next.wstrb = wstrb;
      end
      if (state_reg.bvalid && bready) begin
         state_next.bvalid = 1'b0;
      end

      // Register writes; clears go first so that hardware sets below win
      if (do_write) begin
         state_next.aw_held = 1'b0;
         state_next.w_held = 1'b0;
         state_next.bvalid = 1'b1;
         state_next.bresp = is_mapped(state_reg.awaddr) ? RESP_OKAY : RESP_DECERR;
         case (state_reg.awaddr)
            CTL_OFFSET: begin
               // Reserved bits fall outside both masks and stay zero
               state_next.ctl = (state_reg.ctl & ~(wmask & CTL_RW_MASK)) |
                                (state_reg.wdata & wmask & CTL_RW_MASK);
               state_next.ctl = state_next.ctl &
                                ~(state_reg.wdata & wmask & CTL_W1C_MASK);
            end
            IRQ_STAT_OFFSET: begin
               state_next.irq_stat = state_reg.irq_stat &
                                     ~(state_reg.wdata[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
            end
            IRQ_MASK_OFFSET: begin
               state_next.irq_mask = (state_reg.irq_mask & ~wmask[IRQ_W-1:0]) |
                                     (state_reg.wdata[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
            end
            RESUME_OPT_OFFSET: begin
               state_next.resume_opt =
                  (state_reg.resume_opt & ~wmask[RESUME_OPT_W-1:0]) |
                  (state_reg.wdata[RESUME_OPT_W-1:0] & wmask[RESUME_OPT_W-1:0]);
            end
            default: begin
               state_next.ctl = state_reg.ctl;
            end
         endcase
      end
      state_next.awready = !state_next.aw_held;
      state_next.wready = !state_next.w_held;

      // Read channel: one outstanding read, answered the cycle after it is taken
      if (state_reg.rvalid && rready) begin
         state_next.rvalid = 1'b0;
      end
      if (arvalid && state_reg.arready) begin
         state_next.rvalid = 1'b1;
         state_next.rdata = read_word(state_reg, araddr);
         state_next.rresp = is_mapped(araddr) ? RESP_OKAY : RESP_DECERR;
      end
      state_next.arready = !state_next.rvalid;

      // Resume completion clears, again ahead of the event sets
      if (resume_done && state_reg.resume_opt[RES_CLR_STATUS_BIT]) begin
         state_next.ctl[V6_SYN_SEEN_BIT] = 1'b0;
         state_next.ctl[V4_SYN_SEEN_BIT] = 1'b0;
      end
      if (resume_done && state_reg.resume_opt[RES_CLR_ENABLE_BIT]) begin
         state_next.ctl[V6_SYN_WAKE_BIT] = 1'b0;
         state_next.ctl[V4_SYN_WAKE_BIT] = 1'b0;
      end

      // Checksum gate: bypass leaves only the FCS in force
      checks_ok = rx_check.fcs_ok &&
                  (state_reg.ctl[CHECKSUM_BYPASS_BIT] ||
                   (rx_check.ip_csum_ok && rx_check.l4_csum_ok));

      // Frame decision; frames failing the checks simply go on untouched
      if (rx_check.done) begin
         state_next.verdict.valid = 1'b1;
         state_next.verdict.pass = 1'b1;
         if (checks_ok) begin
            case (rx_check.kind)
               FRAME_ARP: begin
                  ctl_set[ARP_SEEN_BIT] = 1'b1;
                  irq_set[IRQ_ARP_BIT] = 1'b1;
                  if (state_reg.ctl[ARP_OFFLOAD_BIT] && rx_check.targets_me) begin
                     state_next.verdict.answer_arp = 1'b1;
                     state_next.verdict.pass = state_reg.ctl[FWD_ARP_BIT];
                  end
               end
               FRAME_SOLICIT: begin
                  ctl_set[SOLICIT_SEEN_BIT] = 1'b1;
                  irq_set[IRQ_SOLICIT_BIT] = 1'b1;
                  if (state_reg.ctl[SOLICIT_OFFLOAD_BIT] && rx_check.targets_me) begin
                     state_next.verdict.answer_ns = 1'b1;
                     state_next.verdict.pass = state_reg.ctl[FWD_SOLICIT_BIT];
                  end
               end
               FRAME_V4_SYN: begin
                  ctl_set[V4_SYN_SEEN_BIT] = 1'b1;
                  irq_set[IRQ_V4_SYN_BIT] = 1'b1;
                  state_next.verdict.wake = state_reg.ctl[V4_SYN_WAKE_BIT];
               end
               FRAME_V6_SYN: begin
                  ctl_set[V6_SYN_SEEN_BIT] = 1'b1;
                  irq_set[IRQ_V6_SYN_BIT] = 1'b1;
                  state_next.verdict.wake = state_reg.ctl[V6_SYN_WAKE_BIT];
               end
               default: begin
                  state_next.verdict.pass = 1'b1;
               end
            endcase
         end
      end
      irq_set[IRQ_WAKE_BIT] = state_next.verdict.wake;

      // Sets land last: an event in the clearing cycle is kept
      state_next.ctl = state_next.ctl | ctl_set;
      state_next.irq_stat = state_next.irq_stat | irq_set;
      state_next.irq = |(state_next.irq_stat & state_next.irq_mask);
      state_next.advert_sel = state_next.ctl[ADVERT_SRC_SEL_BIT];
   end

   // State register
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= '{default: '0};
         state_reg.ctl <= CTL_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state flops
   assign awready = state_reg.awready;
   assign wready = state_reg.wready;
   assign bvalid = state_reg.bvalid;
   assign bresp = state_reg.bresp;
   assign arready = state_reg.arready;
   assign rvalid = state_reg.rvalid;
   assign rdata = state_reg.rdata;
   assign rresp = state_reg.rresp;
   assign rx_verdict = state_reg.verdict;
   assign advert_sel = state_reg.advert_sel;
   assign irq = state_reg.irq;

   // Checks on the bank's own behaviour
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   AST_CSUM_STRICT: assert property (
      rx_check.done && !state_reg.ctl[CHECKSUM_BYPASS_BIT] && !rx_check.l4_csum_ok
      |=> !rx_verdict.wake && !rx_verdict.answer_arp && !rx_verdict.answer_ns)
      else $error("Frame with bad checksum acted on while bypass clear");

   AST_CSUM_BYPASS: assert property (
      rx_check.done && rx_check.kind == FRAME_ARP && rx_check.fcs_ok &&
      state_reg.ctl[CHECKSUM_BYPASS_BIT]
      |=> state_reg.ctl[ARP_SEEN_BIT])
      else $error("Bypass did not ignore checksum errors on ARP");

   AST_ARP_FWD: assert property (
      rx_verdict.answer_arp |-> rx_verdict.pass == $past(state_reg.ctl[FWD_ARP_BIT]))
      else $error("Offloaded ARP forward decision wrong");

   AST_NS_FWD: assert property (
      rx_verdict.answer_ns |-> rx_verdict.pass == $past(state_reg.ctl[FWD_SOLICIT_BIT]))
      else $error("Offloaded NS forward decision wrong");

   AST_NS_SEEN: assert property (
      rx_check.done && rx_check.kind == FRAME_SOLICIT && checks_ok
      |=> state_reg.ctl[SOLICIT_SEEN_BIT])
      else $error("NS-seen flag not set");

   AST_ARP_STICKY: assert property (
      state_reg.ctl[ARP_SEEN_BIT] && !do_write |=> state_reg.ctl[ARP_SEEN_BIT])
      else $error("ARP-seen flag dropped without a write");

   AST_RESUME_STATUS: assert property (
      resume_done && state_reg.resume_opt[RES_CLR_STATUS_BIT] && !rx_check.done
      |=> !state_reg.ctl[V6_SYN_SEEN_BIT] && !state_reg.ctl[V4_SYN_SEEN_BIT])
      else $error("Resume did not clear SYN-seen flags");

   AST_NS_ANSWER: assert property (
      rx_verdict.answer_ns |-> $past(state_reg.ctl[SOLICIT_OFFLOAD_BIT]))
      else $error("NS answered with offload off");

   AST_V4_WAKE: assert property (
      rx_check.done && rx_check.kind == FRAME_V4_SYN && !state_reg.ctl[V4_SYN_WAKE_BIT]
      |=> !rx_verdict.wake)
      else $error("IPv4 SYN woke while disabled");

   AST_RESUME_ENABLE: assert property (
      resume_done && state_reg.resume_opt[RES_CLR_ENABLE_BIT] && !do_write
      |=> !state_reg.ctl[V6_SYN_WAKE_BIT] && !state_reg.ctl[V4_SYN_WAKE_BIT])
      else $error("Resume did not clear SYN wake enables");

   AST_RESERVED_ZERO: assert property (
      (state_reg.ctl & ~(CTL_RW_MASK | CTL_W1C_MASK)) == '0)
      else $error("Reserved control bits not zero");

   // Addressed word as a plain signal, so the read check samples a net and not a call
   assign rd_word = read_word(state_reg, araddr);

   AST_READ_ANSWER: assert property (
      arvalid && arready |=> rvalid ##0 rdata == $past(rd_word))
      else $error("Read answer late or wrong");

   AST_ADVERT_SEL: assert property (
      do_write && state_reg.awaddr == CTL_OFFSET && wmask[ADVERT_SRC_SEL_BIT]
      |=> advert_sel == $past(state_reg.wdata[ADVERT_SRC_SEL_BIT]))
      else $error("Advertisement source select not taken from the write");

   // A same-cycle ARP record may set the flag again, so that case is left out
   AST_ARP_CLEAR: assert property (
      do_write && state_reg.awaddr == CTL_OFFSET && wmask[ARP_SEEN_BIT] &&
      state_reg.wdata[ARP_SEEN_BIT] && !(rx_check.done && rx_check.kind == FRAME_ARP)
      |=> !state_reg.ctl[ARP_SEEN_BIT])
      else $error("ARP-seen flag survived a write of one");

   AST_V6_SEEN: assert property (
      rx_check.done && rx_check.kind == FRAME_V6_SYN && checks_ok
      |=> state_reg.ctl[V6_SYN_SEEN_BIT])
      else $error("IPv6 SYN-seen flag not set");

   AST_V4_SEEN: assert property (
      rx_check.done && rx_check.kind == FRAME_V4_SYN && checks_ok
      |=> state_reg.ctl[V4_SYN_SEEN_BIT])
      else $error("IPv4 SYN-seen flag not set");

   AST_ARP_ANSWER: assert property (
      rx_verdict.answer_arp |-> $past(state_reg.ctl[ARP_OFFLOAD_BIT]))
      else $error("ARP answered with offload off");

   AST_V6_WAKE: assert property (
      rx_check.done && rx_check.kind == FRAME_V6_SYN && !state_reg.ctl[V6_SYN_WAKE_BIT]
      |=> !rx_verdict.wake)
      else $error("IPv6 SYN woke while disabled");

   // The offload side counts on one decision per record, even back to back
   AST_VERDICT_EACH: assert property (
      rx_check.done |=> rx_verdict.valid)
      else $error("End-of-frame record without a verdict");

endmodule

// *** dv/rx_parser_model.sv ***
// Behavioural receive parser that hands the bank one end-of-frame record per call.
// Assumes the bank samples rx_check on the rising edge of clk.
`timescale 1ns/1ps
module rx_parser_model (
   input  wire logic                   clk,     // Bank clock
   output wake_offload_pkg::rx_check_s rx_check // End-of-frame checks
);
   import wake_offload_pkg::*;
   initial rx_check = '0;
   // One-cycle record; fields toggle between frames so stale values never pass for valid
   task automatic send(input frame_kind_e k, input logic tgt, fcs, ip, l4);
      @(posedge clk);
      rx_check <= '{1'b1, k, tgt, fcs, ip, l4};
      @(posedge clk);
      rx_check <= {1'b0, ~rx_check[6:0]};
   endtask
endmodule

// *** dv/wake_offload_ctrl_status_tb.sv ***
// Self-checking bench for the wake and offload register bank.
// Assumes an AXI4-Lite master of its own and the behavioural receive parser.
`timescale 1ns/1ps
module wake_offload_ctrl_status_tb;
   import wake_offload_pkg::*;
   logic        clk = 0, reset = 1, resume_done = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, ctl_m = '0, u;
   logic [3:0]  wstrb = '0;
   logic        awready, wready, bvalid, arready, rvalid, advert_sel, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [4:0]  ist_m = '0, msk_m = '0;
   rx_check_s   rx_check;
   rx_verdict_s rx_verdict;
   int          failures = 0, check_count = 0, seed = 32145;
   int          sb[5] = '{0, 6, 7, 4, 5};
   int          ib[5] = '{0, 0, 1, 2, 3};

   rx_parser_model i_parser (.clk(clk), .rx_check(rx_check));
   wake_offload_ctrl_status i_dut (.clk(clk), .reset(reset), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .rx_check(rx_check), .resume_done(resume_done),
      .rx_verdict(rx_verdict), .advert_sel(advert_sel), .irq(irq));

   always #5 clk = ~clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // Write one word; the shadow model follows the bank so later reads have a reference
   task automatic wreg(input logic [11:0] a, input logic [31:0] v);
      @(posedge clk);
      awaddr <= a; wdata <= v; wstrb <= 4'hF; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      bready <= 0;
      chk(bresp, (a[11:4] == 8'h60) ? RESP_OKAY : RESP_DECERR);
      if (a == CTL_OFFSET) ctl_m = (v & 32'h8000_070F) | (ctl_m & 32'h0000_00F0 & ~v);
      if (a == IRQ_STAT_OFFSET) ist_m = ist_m & ~v[4:0];
      if (a == IRQ_MASK_OFFSET) msk_m = v[4:0];
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 0;
      end while (!rvalid);
      rready <= 0;
      chk(rdata, e);
      chk(rresp, er);
   endtask

   function automatic rx_verdict_s exp_verdict(frame_kind_e fk, logic t, ok, logic [31:0] c);
      exp_verdict = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      if (ok && fk == FRAME_ARP) exp_verdict.answer_arp = c[2] & t;
      if (ok && fk == FRAME_SOLICIT) exp_verdict.answer_ns = c[3] & t;
      if (exp_verdict.answer_arp) exp_verdict.pass = c[10];
      if (exp_verdict.answer_ns) exp_verdict.pass = c[9];
      if (ok && fk == FRAME_V4_SYN) exp_verdict.wake = c[0];
      if (ok && fk == FRAME_V6_SYN) exp_verdict.wake = c[1];
   endfunction

   // One frame through the parser, then verdict and interrupt line checked; flags only updated in the model
   task automatic frame(input frame_kind_e fk, input logic t, f, i, l);
      logic        ok;
      rx_verdict_s ev;
      ok = f & (ctl_m[31] | (i & l));
      ev = exp_verdict(fk, t, ok, ctl_m);
      i_parser.send(fk, t, f, i, l);
      #1;
      chk(32'(rx_verdict), 32'(ev));
      if (ok && fk != FRAME_OTHER) ctl_m[sb[fk]] = 1'b1;
      if (ok && fk != FRAME_OTHER) ist_m[ib[fk]] = 1'b1;
      if (ev.wake) ist_m[4] = 1'b1;
      chk(32'(irq), 32'(|(ist_m & msk_m)));
   endtask

   task automatic irq_chk(input logic e);
      repeat (2) @(posedge clk);
      #1;
      chk(32'(irq), 32'(e));
   endtask

   task automatic wrap_up;
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // A hang is cut short well beyond the few hundred cycles the sequence needs
   initial begin
      #400000;
      failures++;
      wrap_up;
   end

   initial begin
      repeat (12) @(posedge clk);
      reset <= 0;
      // Reset values, reserved bits and unmapped places
      for (int a = 0; a < 4; a++) rchk(12'h600 + 12'(4 * a), 32'h0, RESP_OKAY);
      rchk(12'h700, 32'h0, RESP_DECERR);
      wreg(CTL_OFFSET, 32'hFFFF_FFFF);
      rchk(CTL_OFFSET, 32'h8000_070F, RESP_OKAY);
      chk(32'(advert_sel), 32'h1);
      wreg(12'h700, 32'h0000_0000);
      rchk(CTL_OFFSET, 32'h8000_070F, RESP_OKAY);
      wreg(CTL_OFFSET, 32'h0000_0000);
      chk(32'(advert_sel), 32'h0);
      // Random configurations and frames, checks often failing on purpose
      for (int n = 0; n < 96; n++) begin
         if (n % 8 == 0) begin
            wreg(CTL_OFFSET, $random(seed));
            rchk(CTL_OFFSET, ctl_m, RESP_OKAY);
            wreg(IRQ_MASK_OFFSET, $random(seed));
         end
         u = $random(seed);
         frame(frame_kind_e'(3'(u[15:0] % 5)), u[16], u[17] | u[18], u[19] | u[20],
               u[21] | u[22]);
      end
      rchk(CTL_OFFSET, ctl_m, RESP_OKAY);
      rchk(IRQ_STAT_OFFSET, 32'(ist_m), RESP_OKAY);
      // Zero leaves the sticky flags alone, a one clears just its own flag
      wreg(CTL_OFFSET, 32'h0000_0000);
      frame(FRAME_ARP, 1'b1, 1'b1, 1'b1, 1'b1);
      rchk(CTL_OFFSET, ctl_m, RESP_OKAY);
      wreg(CTL_OFFSET, 32'h0000_0040);
      rchk(CTL_OFFSET, ctl_m, RESP_OKAY);
      // Interrupt raised, masked, unmasked and cleared
      wreg(IRQ_STAT_OFFSET, 32'h0000_001F);
      wreg(IRQ_MASK_OFFSET, 32'h0000_0001);
      irq_chk(1'b0);
      frame(FRAME_ARP, 1'b0, 1'b1, 1'b0, 1'b1);
      // A bad IP checksum leaves the flag alone; a clean frame then raises it
      frame(FRAME_ARP, 1'b0, 1'b1, 1'b1, 1'b1);
      wreg(IRQ_MASK_OFFSET, 32'h0000_0000);
      irq_chk(1'b0);
      wreg(IRQ_MASK_OFFSET, 32'h0000_0001);
      irq_chk(1'b1);
      wreg(IRQ_STAT_OFFSET, 32'h0000_0001);
      irq_chk(1'b0);
      // Every resume option against set flags and enables
      for (int o = 0; o < 4; o++) begin
         wreg(RESUME_OPT_OFFSET, 32'(o));
         wreg(CTL_OFFSET, 32'h0000_0003);
         frame(FRAME_V4_SYN, 1'b1, 1'b1, 1'b1, 1'b1);
         frame(FRAME_V6_SYN, 1'b1, 1'b1, 1'b1, 1'b1);
         @(posedge clk);
         resume_done <= 1;
         @(posedge clk);
         resume_done <= 0;
         if (o[0]) ctl_m[5:4] = 2'b00;
         if (o[1]) ctl_m[1:0] = 2'b00;
         rchk(CTL_OFFSET, ctl_m, RESP_OKAY);
      end
      wrap_up;
   end
endmodule
